// file: design/ucfc_channel.sv
// One serial channel: registers, mode select, FIFOs, receiver, flow control.
// Assumes a byte register port with read data one cycle after the strobe,
// and serial pins synchronous to i_clk.
//
// The register offsets and the strobed register port were left to the implementer.
`include "ucfc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ucfc_channel
  import ucfc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_rxd,
  output logic            o_txd,
  input  wire logic       i_cts_n,
  output logic            o_rts_n,
  output logic            o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Mode from the special and enhanced bits plus the FIFO enable
  function automatic ucfc_mode_t mode_of(input logic [7:0] special_function_reg, input logic [7:0] enhanced_function_reg,
                                         input logic fifo_en);
    if (!enhanced_function_reg[`UCFC_EFR_ENH]) begin
      mode_of = fifo_en ? UCFC_MODE_FIFO16 : UCFC_MODE_BYTE;
    end else begin
      mode_of = special_function_reg[`UCFC_SFR_ENH] ? UCFC_MODE_FULL : UCFC_MODE_ENH;
    end
  endfunction

  // Usable depth per mode
  function automatic logic [7:0] cap_of(input ucfc_mode_t m);
    unique case (m)
      UCFC_MODE_BYTE:   cap_of = `UCFC_CAP_BYTE;
      UCFC_MODE_FIFO16: cap_of = `UCFC_CAP_16;
      UCFC_MODE_ENH:    cap_of = `UCFC_CAP_128;
      UCFC_MODE_FULL:   cap_of = `UCFC_CAP_128;
    endcase
  endfunction

  // Register write decode, used by every configuration register
  function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] off);
    wr_hit = wr && (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers written by software

  logic [7:0]     ier_q;
  logic [7:0]     lcr_q;
  logic [7:0]     special_function_reg_q;
  logic [7:0]     enhanced_function_reg_q;
  logic [7:0]     xon_char_q;
  logic [7:0]     xoff_char_q;
  logic [7:0]     trig_hi_q;
  logic [7:0]     trig_lo_q;
  logic [7:0]     baud_div_q;
  logic           fifo_en_q;
  logic           rx_flush;
  logic           tx_flush;
  ucfc_mode_t     mode;
  logic [7:0]     cap;

  // Plain read-write configuration
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ier_q                   <= `UCFC_RST_ZERO;
      lcr_q                   <= `UCFC_RST_ZERO;
      special_function_reg_q  <= `UCFC_RST_ZERO;
      enhanced_function_reg_q <= `UCFC_RST_ZERO;
      xon_char_q              <= `UCFC_RST_XON;
      xoff_char_q             <= `UCFC_RST_XOFF;
      trig_hi_q               <= `UCFC_RST_TRIG_HI;
      trig_lo_q               <= `UCFC_RST_TRIG_LO;
      baud_div_q              <= `UCFC_RST_BAUD;
      fifo_en_q               <= 1'b0;
    end else begin
      if (wr_hit(i_wr, i_addr, `UCFC_OFF_IER)) ier_q <= i_wdata;
      if (wr_hit(i_wr, i_addr, `UCFC_OFF_LCR)) lcr_q <= i_wdata;
      if (wr_hit(i_wr, i_addr, `UCFC_OFF_SFR)) special_function_reg_q <= i_wdata;
      if (wr_hit(i_wr, i_addr, `UCFC_OFF_EFR)) enhanced_function_reg_q <= i_wdata;
      if (wr_hit(i_wr, i_addr, `UCFC_OFF_XON)) xon_char_q <= i_wdata;
      if (wr_hit(i_wr, i_addr, `UCFC_OFF_XOFF)) xoff_char_q <= i_wdata;
      if (wr_hit(i_wr, i_addr, `UCFC_OFF_TRIG_HI)) trig_hi_q <= i_wdata;
      if (wr_hit(i_wr, i_addr, `UCFC_OFF_TRIG_LO)) trig_lo_q <= i_wdata;
      if (wr_hit(i_wr, i_addr, `UCFC_OFF_BAUD)) baud_div_q <= i_wdata;
      if (wr_hit(i_wr, i_addr, `UCFC_OFF_FCR)) fifo_en_q <= i_wdata[`UCFC_FCR_EN];
    end
  end

  // FIFO clear bits act once and are not stored
  assign rx_flush = wr_hit(i_wr, i_addr, `UCFC_OFF_FCR) && i_wdata[`UCFC_FCR_RXCLR];
  assign tx_flush = wr_hit(i_wr, i_addr, `UCFC_OFF_FCR) && i_wdata[`UCFC_FCR_TXCLR];

  // Mode decode steers FIFO depth and which extras are live
  assign mode = mode_of(special_function_reg_q, enhanced_function_reg_q, fifo_en_q);
  assign cap  = cap_of(mode);

  ////////////////////////////////////////////////////////////////////////////
  // Baud enable: one pulse every baud_div+1 cycles, sixteen per bit

  logic [7:0] div_q;
  logic       tick;

  assign tick = (div_q == baud_div_q);

  always_ff @(posedge i_clk) begin
    if (i_reset || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs

  ucfc_fifo_if rx_holding_fifo ();
  ucfc_fifo_if tx_holding_fifo ();

  ucfc_fifo u_rx_fifo (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .bus     (rx_holding_fifo)
  );

  ucfc_fifo u_tx_fifo (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .bus     (tx_holding_fifo)
  );

  logic [7:0] rx_fifo_level_count;
  logic [7:0] tx_fifo_level_count;
  logic       host_data_wr;
  logic       host_data_rd;
  logic       tx_pop;
  logic       rx_push;
  logic [7:0] rx_char_q;

  assign host_data_wr = wr_hit(i_wr, i_addr, `UCFC_OFF_DATA);
  assign host_data_rd = i_rd && (i_addr == `UCFC_OFF_DATA);

  // Host writes go to the tail; a write while full is dropped by the FIFO
  assign tx_holding_fifo.push      = host_data_wr;
  assign tx_holding_fifo.push_data = i_wdata;
  assign tx_holding_fifo.pop       = tx_pop;
  assign tx_holding_fifo.flush     = tx_flush;
  assign tx_holding_fifo.cap       = cap;

  // Reads of an empty receive FIFO pop nothing and return stale data
  assign rx_holding_fifo.push      = rx_push;
  assign rx_holding_fifo.push_data = rx_char_q;
  assign rx_holding_fifo.pop       = host_data_rd;
  assign rx_holding_fifo.flush     = rx_flush;
  assign rx_holding_fifo.cap       = cap;

  assign rx_fifo_level_count = rx_holding_fifo.count;
  assign tx_fifo_level_count = tx_holding_fifo.count;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: start found on a tick, bits sampled mid-cell

  ucfc_rx_state_t rx_state_q;
  logic [3:0]     rx_ovs_q;
  logic [2:0]     rx_bit_q;
  logic [7:0]     rx_sh_q;
  logic           rx_par_q;
  logic           rx_done_q;
  logic           rx_ferr_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_state_q <= UCFC_RX_IDLE;
      rx_ovs_q   <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_sh_q    <= 8'h00;
      rx_par_q   <= 1'b0;
      rx_done_q  <= 1'b0;
      rx_ferr_q  <= 1'b0;
      rx_char_q  <= 8'h00;
    end else begin
      rx_done_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      if (tick) begin
        rx_ovs_q <= rx_ovs_q + 4'h1;
        unique case (rx_state_q)
          UCFC_RX_IDLE: begin
            rx_ovs_q <= 4'h0;
            if (!i_rxd) rx_state_q <= UCFC_RX_START;
          end
          UCFC_RX_START: begin
            // Half a bit in: a high line means a glitch, not a start
            if (rx_ovs_q == `UCFC_OVS_MID) begin
              rx_ovs_q   <= 4'h0;
              rx_bit_q   <= 3'h0;
              rx_state_q <= i_rxd ? UCFC_RX_IDLE : UCFC_RX_DATA;
            end
          end
          UCFC_RX_DATA: begin
            if (rx_ovs_q == `UCFC_OVS_LAST) begin
              rx_sh_q  <= {i_rxd, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == 3'h7) begin
                rx_state_q <= lcr_q[`UCFC_LCR_PAREN] ? UCFC_RX_PAR : UCFC_RX_STOP;
              end
            end
          end
          UCFC_RX_PAR: begin
            if (rx_ovs_q == `UCFC_OVS_LAST) begin
              rx_par_q   <= i_rxd;
              rx_state_q <= UCFC_RX_STOP;
            end
          end
          UCFC_RX_STOP: begin
            // Only a high stop bit delivers a character
            if (rx_ovs_q == `UCFC_OVS_LAST) begin
              rx_done_q  <= i_rxd;
              rx_ferr_q  <= !i_rxd;
              rx_char_q  <= rx_sh_q;
              rx_state_q <= UCFC_RX_IDLE;
            end
          end
          default: rx_state_q <= UCFC_RX_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // In-band flow control, live only in fully enhanced mode

  logic inb_tx_en;
  logic inb_rx_en;
  logic is_xon;
  logic is_xoff;
  logic xoff_seen_q;

  assign inb_tx_en = (mode == UCFC_MODE_FULL) && (enhanced_function_reg_q[3:2] != 2'b00);
  assign inb_rx_en = (mode == UCFC_MODE_FULL) && (enhanced_function_reg_q[1:0] != 2'b00);
  assign is_xon    = rx_done_q && inb_tx_en && (rx_char_q == xon_char_q);
  assign is_xoff   = rx_done_q && inb_tx_en && (rx_char_q == xoff_char_q);

  // Control characters steer the transmitter and are not stored
  assign rx_push = rx_done_q && !is_xon && !is_xoff;

  // XOFF holds the next start; XON releases it on the following cycle
  always_ff @(posedge i_clk) begin
    if (i_reset || !inb_tx_en) begin
      xoff_seen_q <= 1'b0;
    end else if (is_xoff) begin
      xoff_seen_q <= 1'b1;
    end else if (is_xon) begin
      xoff_seen_q <= 1'b0;
    end
  end

  // Local receive level drives XOFF/XON requests toward the remote end
  logic remote_held_q;
  logic pend_xoff_q;
  logic pend_xon_q;
  logic send_xoff;
  logic send_xon;

  always_ff @(posedge i_clk) begin
    if (i_reset || !inb_rx_en) begin
      remote_held_q <= 1'b0;
      pend_xoff_q   <= 1'b0;
      pend_xon_q    <= 1'b0;
    end else begin
      if (!remote_held_q && rx_fifo_level_count >= trig_hi_q) begin
        remote_held_q <= 1'b1;
        pend_xoff_q   <= 1'b1;
        pend_xon_q    <= 1'b0;
      end else if (remote_held_q && rx_fifo_level_count < trig_lo_q) begin
        remote_held_q <= 1'b0;
        pend_xon_q    <= 1'b1;
        pend_xoff_q   <= 1'b0;
      end else begin
        if (send_xoff) pend_xoff_q <= 1'b0;
        if (send_xon) pend_xon_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit start selection

  logic       cts_hold;
  logic       tx_busy;
  logic       tx_start;
  logic [7:0] tx_byte;

  // Gating only the start lets the shifting character finish
  assign cts_hold  = enhanced_function_reg_q[`UCFC_EFR_CTS] && !i_cts_n;
  assign send_xoff = !cts_hold && !tx_busy && pend_xoff_q;
  assign send_xon  = !cts_hold && !tx_busy && !pend_xoff_q && pend_xon_q;
  assign tx_pop    = !cts_hold && !tx_busy && !pend_xoff_q && !pend_xon_q
                     && !xoff_seen_q && !tx_holding_fifo.empty;
  assign tx_start  = send_xoff || send_xon || tx_pop;
  assign tx_byte   = send_xoff ? xoff_char_q : (send_xon ? xon_char_q : tx_holding_fifo.pop_data);

  ucfc_serial_tx u_tx (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_tick     (tick),
    .i_start    (tx_start),
    .i_data     (tx_byte),
    .i_par_en   (lcr_q[`UCFC_LCR_PAREN]),
    .i_par_even (lcr_q[`UCFC_LCR_PAREVEN]),
    .i_two_stop (lcr_q[`UCFC_LCR_2STOP]),
    .o_busy     (tx_busy),
    .o_txd      (o_txd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request-to-send hysteresis

  logic rts_hold_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rts_hold_q <= 1'b0;
      o_rts_n    <= 1'b0;
    end else begin
      if (rx_fifo_level_count >= trig_hi_q) begin
        rts_hold_q <= 1'b1;
      end else if (rx_fifo_level_count < trig_lo_q) begin
        rts_hold_q <= 1'b0;
      end
      // Disabled handshake leaves the line asserted
      o_rts_n <= enhanced_function_reg_q[`UCFC_EFR_RTS] && rts_hold_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line status: sticky flags clear on status read, a new event wins

  logic rx_ovr_q;
  logic tx_ovr_q;
  logic ferr_q;
  logic lsr_rd;
  logic tx_idle;
  logic [7:0] line_status_reg;

  assign lsr_rd  = i_rd && (i_addr == `UCFC_OFF_LSR);
  assign tx_idle = !tx_busy && tx_holding_fifo.empty;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_ovr_q <= 1'b0;
      tx_ovr_q <= 1'b0;
      ferr_q   <= 1'b0;
    end else begin
      rx_ovr_q <= (rx_push && rx_holding_fifo.full) || (rx_ovr_q && !lsr_rd);
      tx_ovr_q <= (host_data_wr && tx_holding_fifo.full) || (tx_ovr_q && !lsr_rd);
      ferr_q   <= rx_ferr_q || (ferr_q && !lsr_rd);
    end
  end

  assign line_status_reg = {ferr_q, tx_idle, tx_holding_fifo.empty, tx_holding_fifo.full,
                            tx_ovr_q, rx_holding_fifo.full, rx_ovr_q,
                            !rx_holding_fifo.empty};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and read port

  // Level request: transmitter ready for data or receive data waiting
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (ier_q[`UCFC_IER_TX] && tx_holding_fifo.empty)
               || (ier_q[`UCFC_IER_RX] && !rx_holding_fifo.empty);
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      unique case (i_addr)
        `UCFC_OFF_DATA:    o_rdata <= rx_holding_fifo.pop_data;
        `UCFC_OFF_IER:     o_rdata <= ier_q;
        `UCFC_OFF_FCR:     o_rdata <= {7'h00, fifo_en_q};
        `UCFC_OFF_LCR:     o_rdata <= lcr_q;
        `UCFC_OFF_SFR:     o_rdata <= special_function_reg_q;
        `UCFC_OFF_EFR:     o_rdata <= enhanced_function_reg_q;
        `UCFC_OFF_LSR:     o_rdata <= line_status_reg;
        `UCFC_OFF_RXCNT:   o_rdata <= rx_fifo_level_count;
        `UCFC_OFF_TXCNT:   o_rdata <= tx_fifo_level_count;
        `UCFC_OFF_XON:     o_rdata <= xon_char_q;
        `UCFC_OFF_XOFF:    o_rdata <= xoff_char_q;
        `UCFC_OFF_TRIG_HI: o_rdata <= trig_hi_q;
        `UCFC_OFF_TRIG_LO: o_rdata <= trig_lo_q;
        `UCFC_OFF_BAUD:    o_rdata <= baud_div_q;
        default:           o_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: design/ucfc_defines.svh
// Constants for one serial channel with FIFOs and flow control.
// Assumes a single 200 MHz clock and a byte-wide register port.
//
// Notes on behaviour
// - Mode comes from special and enhanced bits.
// - Enhanced bit clear ignores special bit five.
// - Byte mode holds one byte each way.
// - Basic FIFO mode holds sixteen bytes each.
// - Enhanced bit only gives 128-byte FIFOs.
// - Fully enhanced: 128 bytes plus extra features.
// - Oldest byte shifts out with framing bits.
// - Transmitter idles when shifter and FIFO empty.
// - Write to full transmit FIFO is overrun.
// - Received byte appended; full means overrun.
// - FIFO empty and full flags in status.
// - Interrupt when transmitter ready or data waiting.
// - Readable byte counters for both FIFOs.
// - XOFF stops sending after current character.
// - XON resumes sending at once.
// - Enhanced bits 1:0 receive, 3:2 transmit.
// - Clear-to-send asserted halts after current character.
// - Drop request-to-send at upper trigger level.
// - Raise request-to-send below lower trigger level.
// - Enhanced bits 7:6 enable handshake flow.
`ifndef UCFC_DEFINES_SVH
`define UCFC_DEFINES_SVH

// Register offsets
`define UCFC_OFF_DATA     4'h0
`define UCFC_OFF_IER      4'h1
`define UCFC_OFF_FCR      4'h2
`define UCFC_OFF_LCR      4'h3
`define UCFC_OFF_SFR      4'h4
`define UCFC_OFF_EFR      4'h5
`define UCFC_OFF_LSR      4'h6
`define UCFC_OFF_RXCNT    4'h7
`define UCFC_OFF_TXCNT    4'h8
`define UCFC_OFF_XON      4'h9
`define UCFC_OFF_XOFF     4'ha
`define UCFC_OFF_TRIG_HI  4'hb
`define UCFC_OFF_TRIG_LO  4'hc
`define UCFC_OFF_BAUD     4'hd

// Field positions
`define UCFC_SFR_ENH      5
`define UCFC_EFR_ENH      4
`define UCFC_EFR_RTS      6
`define UCFC_EFR_CTS      7
`define UCFC_FCR_EN       0
`define UCFC_FCR_RXCLR    1
`define UCFC_FCR_TXCLR    2
`define UCFC_LCR_2STOP    2
`define UCFC_LCR_PAREN    3
`define UCFC_LCR_PAREVEN  4
`define UCFC_IER_RX       0
`define UCFC_IER_TX       1

// Reset values
`define UCFC_RST_XON      8'h11
`define UCFC_RST_XOFF     8'h13
`define UCFC_RST_TRIG_HI  8'h60
`define UCFC_RST_TRIG_LO  8'h20
`define UCFC_RST_BAUD     8'h01
`define UCFC_RST_ZERO     8'h00

// FIFO capacities and storage
`define UCFC_CAP_BYTE     8'h01
`define UCFC_CAP_16       8'h10
`define UCFC_CAP_128      8'h80
`define UCFC_FIFO_AW      7

// Oversampling: sixteen baud ticks per bit
`define UCFC_OVS_MID      4'h7
`define UCFC_OVS_LAST     4'hf

`endif

// file: design/ucfc_pkg.sv
// Types shared by the serial channel modules.
// Assumes ucfc_defines.svh supplies every number.
package ucfc_pkg;

  // Operating modes of the channel
  typedef enum logic [1:0] {
    UCFC_MODE_BYTE   = 2'b00,
    UCFC_MODE_FIFO16 = 2'b01,
    UCFC_MODE_ENH    = 2'b10,
    UCFC_MODE_FULL   = 2'b11
  } ucfc_mode_t;

  // Receiver states
  typedef enum logic [2:0] {
    UCFC_RX_IDLE  = 3'b000,
    UCFC_RX_START = 3'b001,
    UCFC_RX_DATA  = 3'b010,
    UCFC_RX_PAR   = 3'b011,
    UCFC_RX_STOP  = 3'b100
  } ucfc_rx_state_t;

endpackage

// file: design/ucfc_fifo_if.sv
// Carrier between the channel and one of its byte FIFOs.
// Assumes the owner drives requests and the store answers combinationally.
`timescale 1ns/1ps
`default_nettype none
interface ucfc_fifo_if;
  logic       push;
  logic [7:0] push_data;
  logic       pop;
  logic       flush;
  logic [7:0] cap;
  logic [7:0] pop_data;
  logic [7:0] count;
  logic       full;
  logic       empty;

  modport owner (output push, push_data, pop, flush, cap,
                 input  pop_data, count, full, empty);
  modport store (input  push, push_data, pop, flush, cap,
                 output pop_data, count, full, empty);
endinterface
`default_nettype wire

// file: design/ucfc_fifo.sv
// Byte FIFO of 128 entries whose usable depth is set by cap.
// Assumes the owner never changes cap while bytes above it are held.
`include "ucfc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ucfc_fifo (
  input wire logic     i_clk,
  input wire logic     i_reset,
  ucfc_fifo_if.store   bus
);
  logic [7:0]               mem_q [0:(1 << `UCFC_FIFO_AW) - 1];
  logic [`UCFC_FIFO_AW-1:0] wr_q;
  logic [`UCFC_FIFO_AW-1:0] rd_q;
  logic [7:0]               cnt_q;
  logic                     push_ok;
  logic                     pop_ok;

  // Full follows the mode's capacity, so byte mode holds one entry
  assign bus.full     = (cnt_q >= bus.cap);
  assign bus.empty    = (cnt_q == 8'h00);
  assign bus.count    = cnt_q;
  assign bus.pop_data = mem_q[rd_q];
  assign push_ok      = bus.push && !bus.full;
  assign pop_ok       = bus.pop && !bus.empty;

  // Storage has no reset; only pointers and count define contents
  always_ff @(posedge i_clk) begin
    if (push_ok) begin
      mem_q[wr_q] <= bus.push_data;
    end
  end

  // Pointers wrap naturally at the array size
  always_ff @(posedge i_clk) begin
    if (i_reset || bus.flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= 8'h00;
    end else begin
      if (push_ok) wr_q <= wr_q + 1'b1;
      if (pop_ok) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {7'h00, push_ok} - {7'h00, pop_ok};
    end
  end
endmodule
`default_nettype wire

// file: design/ucfc_serial_tx.sv
// Transmit shifter: start bit, eight data bits, optional parity, stop bits.
// Assumes i_start only while o_busy is low; i_tick is the 16x baud enable.
`include "ucfc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ucfc_serial_tx (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_tick,
  input  wire logic       i_start,
  input  wire logic [7:0] i_data,
  input  wire logic       i_par_en,
  input  wire logic       i_par_even,
  input  wire logic       i_two_stop,
  output logic            o_busy,
  output logic            o_txd
);
  logic [11:0] sh_q;
  logic [3:0]  nbits_q;
  logic [3:0]  ovs_q;
  logic        par;

  assign par    = i_par_even ? ^i_data : ~^i_data;
  assign o_busy = (nbits_q != 4'h0);

  // Frame is loaded whole and shifted out LSB first
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sh_q    <= 12'hfff;
      nbits_q <= 4'h0;
      ovs_q   <= 4'h0;
      o_txd   <= 1'b1;
    end else if (i_start && !o_busy) begin
      sh_q    <= i_par_en ? {2'b11, par, i_data, 1'b0} : {3'b111, i_data, 1'b0};
      nbits_q <= 4'ha + {3'h0, i_par_en} + {3'h0, i_two_stop};
      ovs_q   <= 4'h0;
    end else if (o_busy && i_tick) begin
      o_txd <= sh_q[0];
      ovs_q <= ovs_q + 4'h1;
      if (ovs_q == `UCFC_OVS_LAST) begin
        sh_q    <= {1'b1, sh_q[11:1]};
        nbits_q <= nbits_q - 4'h1;
      end
    end else if (!o_busy) begin
      o_txd <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: bench/ucfc_monitor.sv
// Port checker for one serial channel.
// Assumes it is bound to ucfc_channel and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ucfc_monitor (
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_rxd,
  input wire logic       o_txd,
  input wire logic       i_cts_n,
  input wire logic       o_rts_n,
  input wire logic       o_irq
);
  logic [7:0] efr_q, ier_q, hi_q, bd_q, low_q, cts_q;
  logic       wr0_q, rxs_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // Shadow of the writes that shape pin behaviour
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      {efr_q, ier_q, hi_q, bd_q, wr0_q} <= {16'h0000, 8'h60, 8'h01, 1'b0};
    end else if (i_wr) begin
      case (i_addr)
        4'h0: wr0_q <= 1'b1;
        4'h1: ier_q <= i_wdata;
        4'h5: efr_q <= i_wdata;
        4'hb: hi_q <= i_wdata;
        4'hd: bd_q <= i_wdata;
        default: ;
      endcase
    end
  end
  // Run lengths of a low line and of a stall; the stall count saturates
  always_ff @(posedge i_clk) begin
    low_q <= (i_reset || o_txd) ? 8'h00 : low_q + 8'h01;
    cts_q <= (i_reset || i_cts_n) ? 8'h00 : cts_q + {7'h00, cts_q != 8'hff};
    rxs_q <= !i_reset && (rxs_q || !i_rxd);
  end
  AST_RESET_IDLE: assert property ($fell(i_reset) |-> o_txd && !o_irq && !o_rts_n && o_rdata == 8'h00)
    else $error("outputs busy after reset");
  AST_RDATA_STANDS: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its cycle");
  AST_BIT_TIME: assert property ($rose(o_txd) && bd_q == 8'h00 |-> low_q[3:0] == 4'h0 && low_q != 8'h00)
    else $error("low run not whole bits");
  AST_CTS_HOLD: assert property (efr_q[7] && bd_q == 8'h00 && cts_q >= 8'hd0 |-> o_txd)
    else $error("sending during stall");
  AST_RTS_OFF: assert property (!efr_q[6] && !$past(efr_q[6]) |-> !o_rts_n)
    else $error("request line high while disabled");
  AST_IRQ_MASKED: assert property (ier_q == 8'h00 && $past(ier_q) == 8'h00 |-> !o_irq)
    else $error("interrupt while masked");
  AST_TX_QUIET: assert property (!wr0_q |-> o_txd)
    else $error("line active with no data");
  AST_RTS_EMPTY_RX: assert property (!rxs_q && hi_q != 8'h00 |-> !o_rts_n)
    else $error("request line high with nothing received");
endmodule
bind ucfc_channel ucfc_monitor mon (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_rxd,
  .o_txd, .i_cts_n, .o_rts_n, .o_irq);
`default_nettype wire

// file: bench/ucfc_remote_model.sv
// Remote serial end: sends 8N1 chars and decodes what the channel sends.
// Assumes 16 clocks a bit, i.e. baud divisor 0.
`timescale 1ns/1ps
`default_nettype none
module ucfc_remote_model (
  input  wire logic i_clk,
  input  wire logic i_txd,
  input  wire logic i_rts_n,
  output logic      o_rxd,
  output logic      o_cts_n
);
  logic [7:0] got;
  int         n_got = 0, room = 255;
  // Line idles high; clear-to-send drops once room chars have been taken
  initial o_rxd = 1'b1;
  assign o_cts_n = (n_got < room);
  // One char, LSB first; holds off while the channel asks for a pause
  task automatic send(input logic [7:0] b);
    while (i_rts_n) @(posedge i_clk);
    for (int i = 0; i < 10; i++) begin
      o_rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
      repeat (16) @(posedge i_clk);
    end
  endtask
  // Decoder samples mid-bit, so edge jitter of a cycle is harmless
  always begin
    @(negedge i_txd);
    repeat (24) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      got[i] = i_txd;
      repeat (16) @(posedge i_clk);
    end
    n_got++;
  end
endmodule
`default_nettype wire

// file: bench/ucfc_channel_tb.sv
// Self-checking bench for one serial channel.
// Assumes the remote model at the serial pins and baud divisor 0.
`timescale 1ns/1ps
`default_nettype none
module ucfc_channel_tb;
  logic       i_clk, i_reset, i_wr, i_rd, o_txd, o_rts_n, o_irq, rxd, cts_n;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata;
  int         n_errors, tests_run, cyc;
  // Per mode: control, special, enhanced, capacity
  logic [7:0] tbl [5][4] = '{'{8'h00, 8'h00, 8'h80, 8'h01}, '{8'h01, 8'h00, 8'h80, 8'h10},
    '{8'h01, 8'h20, 8'h80, 8'h10}, '{8'h01, 8'h00, 8'h90, 8'h80}, '{8'h01, 8'h20, 8'h90, 8'h80}};
  ucfc_channel dut (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_rxd(rxd), .o_txd,
    .i_cts_n(cts_n), .o_rts_n, .o_irq);
  ucfc_remote_model rem (.i_clk, .i_txd(o_txd), .i_rts_n(o_rts_n), .o_rxd(rxd), .o_cts_n(cts_n));
  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h at %0t", s, e, g, $time);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge i_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata & m);
  endtask
  task automatic pin(input string s, input logic e);
    repeat (4) @(posedge i_clk);
    #1 chk(s, {7'h00, e}, {7'h00, (s == "irq") ? o_irq : o_rts_n});
  endtask
  // Main sequence
  initial begin
    {i_reset, i_wr, i_rd, i_addr, i_wdata} = {3'b100, 4'h0, 8'h00};
    repeat (6) @(posedge i_clk);
    i_reset <= 1'b0;
    rdc(4'h6, 8'h60, 8'hff);
    rdc(4'hb, 8'h60, 8'hff);
    wr(4'hd, 8'h00);
    wr(4'h1, 8'h02);
    pin("irq", 1'b1);
    wr(4'h1, 8'h00);
    // Byte mode: the second char finds the slot taken
    rem.send(8'h3c);
    rem.send(8'hc3);
    repeat (20) @(posedge i_clk);
    rdc(4'h7, 8'h01, 8'hff);
    rdc(4'h6, 8'h02, 8'h02);
    rdc(4'h0, 8'h3c, 8'hff);
    // Every mode: stall the line and overfill the transmit side
    rem.room <= 0;
    foreach (tbl[i]) begin
      wr(4'h4, tbl[i][1]);
      wr(4'h5, tbl[i][2]);
      wr(4'h2, tbl[i][0]);
      for (int k = 0; k <= tbl[i][3]; k++) wr(4'h0, k[7:0]);
      rdc(4'h8, tbl[i][3], 8'hff);
      rdc(4'h6, 8'h18, 8'h18);
      wr(4'h2, tbl[i][0] | 8'h04);
    end
    // A held char leaves only once the stall ends
    wr(4'h0, 8'ha5);
    repeat (400) @(posedge i_clk);
    chk("chars", 8'h00, 8'(rem.n_got));
    rem.room <= 255;
    for (int k = 0; k < 400 && rem.n_got != 1; k++) @(posedge i_clk);
    chk("txchar", 8'ha5, rem.got);
    repeat (16) @(posedge i_clk);
    rdc(4'h6, 8'h60, 8'h60);
    // In-band pause and resume, control chars not stored
    wr(4'h5, 8'h1c);
    rem.send(8'h13);
    wr(4'h0, 8'h5a);
    repeat (400) @(posedge i_clk);
    chk("chars", 8'h01, 8'(rem.n_got));
    rem.send(8'h11);
    for (int k = 0; k < 400 && rem.n_got != 2; k++) @(posedge i_clk);
    chk("txchar", 8'h5a, rem.got);
    rdc(4'h7, 8'h00, 8'hff);
    // Request line drops at the upper level, returns only below the lower
    wr(4'hb, 8'h02);
    wr(4'hc, 8'h01);
    wr(4'h5, 8'h53);
    rem.send(8'h01);
    rem.send(8'h02);
    pin("rts_n", 1'b1);
    rdc(4'h0, 8'h01, 8'hff);
    pin("rts_n", 1'b1);
    rdc(4'h0, 8'h02, 8'hff);
    pin("rts_n", 1'b0);
    for (int k = 0; k < 400 && rem.n_got != 4; k++) @(posedge i_clk);
    chk("txchar", 8'h11, rem.got);
    print_verdict();
  end
endmodule
`default_nettype wire
